// >>> link_control_bank.sv
`timescale 1ns/100ps
module link_control_bank (
   input wire logic clk, // Core clock, 50 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic cfg_wr, // Config write strobe
   input wire logic cfg_rd, // Config read strobe
   input wire logic [11:0] cfg_addr, // Config byte address
   input wire logic [1:0] cfg_be, // Byte enables
   input wire logic [15:0] cfg_wdata, // Write data
   output logic [15:0] cfg_rdata, // Read data
   output logic cfg_rvalid, // Read data valid
   input wire logic [3:0] ltssm_state, // Training state machine state
   input wire logic link_down, // Data link went down
   input wire logic auto_bw_event, // Autonomous bandwidth change seen
   input wire logic [3:0] cur_speed, // Current operating speed
   input wire logic [3:0] target_speed, // Target link speed field
   output logic to_recovery, // Pulse: go to recovery
   output logic speed_change, // Pulse: negotiate to target speed
   output logic [3:0] retrain_speed, // Speed to negotiate
   output logic to_disabled, // Level: move to disabled
   output logic to_detect, // Level: leave disabled for detect
   output logic ext_sync, // Extra ordered sets
   output logic l0s_tx_en, // Transmit L0s allowed
   output logic bw_intr // Pulse: bandwidth interrupt
);
   typedef struct packed {
      logic [15:0] ctl;
      logic [15:0] rdata;
      logic rvalid;
      logic recovery;
      logic speed_chg;
      logic [3:0] speed;
      logic disabled;
      logic detect;
      logic irq;
   } bank_state_type;

   bank_state_type s;
   bank_state_type next_s;
   link_control_pkg::ltssm_type st;
   link_event_if ev ();
   logic wr_ctl;
   logic rd_ctl;
   logic wr_sts;
   logic rd_sts;
   logic retrain_req;
   logic retrain_ok;
   logic [15:0] ctl_written;
   logic [15:0] sts_word;

   assign st = link_control_pkg::ltssm_type'(ltssm_state);
   assign wr_ctl = cfg_wr && cfg_addr == link_control_pkg::LINK_CONTROL_OFS;
   assign rd_ctl = cfg_rd && cfg_addr == link_control_pkg::LINK_CONTROL_OFS;
   assign wr_sts = cfg_wr && cfg_addr == link_control_pkg::LINK_STATUS_OFS;
   assign rd_sts = cfg_rd && cfg_addr == link_control_pkg::LINK_STATUS_OFS;
   assign retrain_req = wr_ctl && cfg_be[0] && cfg_wdata[link_control_pkg::BIT_RETRAIN];
   // Retrain honoured only from L0, L0s or L1
   assign retrain_ok = retrain_req && link_control_pkg::in_active(st); // RULE_07 RULE_08
   // Reserved, fixed and retrain bits never stored
   assign ctl_written = link_control_pkg::merge_bytes(s.ctl, cfg_wdata, cfg_be)
                        & link_control_pkg::CTL_WR_MASK; // RULE_03 RULE_04 RULE_09 RULE_14 RULE_16

   assign ev.ltssm = st;
   assign ev.link_down = link_down;
   assign ev.auto_bw_event = auto_bw_event;
   assign ev.retrain_go = retrain_ok;
   assign ev.clr_bwm = wr_sts && cfg_be[1] && cfg_wdata[link_control_pkg::STS_BWM];
   assign ev.clr_abw = wr_sts && cfg_be[1] && cfg_wdata[link_control_pkg::STS_ABW];

   link_event_tracker u_tracker (
      .clk(clk),
      .rst_n(rst_n),
      .ev(ev.tracker)
   );

   always_comb
   begin
      sts_word = 16'h0000;
      sts_word[link_control_pkg::STS_ABW] = ev.abw_status;
      sts_word[link_control_pkg::STS_BWM] = ev.bwm_status;
      sts_word[link_control_pkg::STS_TRAIN] = ev.training; // RULE_18
   end

   always_comb
   begin
      next_s = s;
      if (wr_ctl)
         next_s.ctl = ctl_written; // RULE_06
      // New field values land on the same edge as the recovery request
      next_s.recovery = retrain_ok; // RULE_11
      next_s.speed_chg = retrain_ok && target_speed != link_control_pkg::SPEED_NONE
                         && target_speed != cur_speed; // RULE_10
      if (retrain_ok)
         next_s.speed = target_speed; // RULE_10
      next_s.disabled = next_s.ctl[link_control_pkg::BIT_DISABLE]
                        && link_control_pkg::past_polling(st); // RULE_12
      next_s.detect = !next_s.ctl[link_control_pkg::BIT_DISABLE]
                      && st == link_control_pkg::ST_DISABLED; // RULE_13
      next_s.irq = (ev.abw_set_pulse && s.ctl[link_control_pkg::BIT_ABW_IE]) // RULE_01
                   || (ev.bwm_set_pulse && s.ctl[link_control_pkg::BIT_BWM_IE]); // RULE_02
      next_s.rvalid = cfg_rd;
      next_s.rdata = 16'h0000;
      if (rd_ctl)
         next_s.rdata = s.ctl; // RULE_09 RULE_16
      else if (rd_sts)
         next_s.rdata = sts_word;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.ctl <= link_control_pkg::CTL_RESET;
      end
      else
         s <= next_s;
   end

   assign cfg_rdata = s.rdata;
   assign cfg_rvalid = s.rvalid;
   assign to_recovery = s.recovery;
   assign speed_change = s.speed_chg;
   assign retrain_speed = s.speed;
   assign to_disabled = s.disabled;
   assign to_detect = s.detect;
   assign ext_sync = s.ctl[link_control_pkg::BIT_EXT_SYNC]; // RULE_05
   assign l0s_tx_en = link_control_pkg::aspm_l0s(
                         s.ctl[link_control_pkg::BIT_ASPM_HI:link_control_pkg::BIT_ASPM_LO]); // RULE_15
   assign bw_intr = s.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_ctl_read;
      rd_ctl;
   endsequence

   sequence s_retrain_active;
      retrain_req && link_control_pkg::in_active(st);
   endsequence

   sequence s_retrain_idle;
      retrain_req && !link_control_pkg::in_active(st);
   endsequence

   sequence s_low_write(int bit_pos);
      wr_ctl && cfg_be[0] && cfg_wdata[bit_pos];
   endsequence

   a_abw_irq: assert property (ev.abw_set_pulse && s.ctl[link_control_pkg::BIT_ABW_IE] // RULE_01
                               |=> bw_intr)
      else $error("autonomous bandwidth interrupt missing");
   a_irq_cause: assert property (bw_intr |-> // RULE_01
                                 $past(ev.abw_set_pulse && s.ctl[link_control_pkg::BIT_ABW_IE])
                                 || $past(ev.bwm_set_pulse && s.ctl[link_control_pkg::BIT_BWM_IE]))
      else $error("interrupt without an enabled cause");
   a_bwm_irq: assert property (ev.bwm_set_pulse && s.ctl[link_control_pkg::BIT_BWM_IE] // RULE_02
                               |=> bw_intr)
      else $error("bandwidth management interrupt missing");
   a_width_zero: assert property (s_ctl_read |=> !cfg_rdata[link_control_pkg::BIT_AUTO_WIDTH]) // RULE_03
      else $error("autonomous width bit not zero");
   a_clkpm_zero: assert property (s_ctl_read |=> !cfg_rdata[link_control_pkg::BIT_CLK_PM]) // RULE_04
      else $error("clock power management bit not zero");
   a_ext_sync: assert property (s_low_write(link_control_pkg::BIT_EXT_SYNC) |=> ext_sync) // RULE_05
      else $error("extended sync not applied");
   a_retrain_go: assert property (s_retrain_active ##1 !retrain_ok // RULE_07
                                  |-> to_recovery ##1 !to_recovery)
      else $error("recovery not requested for one cycle");
   a_retrain_drop: assert property (s_retrain_idle |=> !to_recovery) // RULE_08
      else $error("retrain honoured outside L0, L0s, L1");
   a_retrain_zero: assert property (s_ctl_read |=> !cfg_rdata[link_control_pkg::BIT_RETRAIN]) // RULE_09
      else $error("retrain bit read back nonzero");
   a_speed_neg: assert property (s_retrain_active // RULE_10
                                 and (target_speed != link_control_pkg::SPEED_NONE
                                 && target_speed != cur_speed)
                                 |=> speed_change && retrain_speed == $past(target_speed))
      else $error("target speed not negotiated");
   a_same_access: assert property (s_retrain_active ##0 s_low_write(link_control_pkg::BIT_EXT_SYNC) // RULE_11
                                   |=> to_recovery && ext_sync)
      else $error("field written with retrain not applied");
   a_link_disable: assert property (s_low_write(link_control_pkg::BIT_DISABLE) // RULE_12
                                    and link_control_pkg::past_polling(st) |=> to_disabled)
      else $error("disable request missing");
   a_back_detect: assert property (!s.ctl[link_control_pkg::BIT_DISABLE] && !wr_ctl // RULE_13
                                   && st == link_control_pkg::ST_DISABLED |=> to_detect)
      else $error("disabled state not released to detect");
   a_rcb_zero: assert property (s_ctl_read |=> !cfg_rdata[link_control_pkg::BIT_RCB]) // RULE_14
      else $error("completion boundary bit not zero");
   a_l0s_enable: assert property (wr_ctl && cfg_be[0] // RULE_15
                                  |=> l0s_tx_en == $past(cfg_wdata[link_control_pkg::BIT_ASPM_LO]))
      else $error("transmit L0s enable wrong");
   a_rsvd_zero: assert property (s_ctl_read |=> (cfg_rdata & link_control_pkg::CTL_ZERO_MASK) // RULE_16
                                 == 16'h0000)
      else $error("reserved or fixed bits not zero");
   a_train_read: assert property (rd_sts && ev.training // RULE_18
                                  |=> cfg_rdata[link_control_pkg::STS_TRAIN])
      else $error("training flag not visible");

   // Bus answers, stored fields and output levels
   sequence s_sts_read;
      rd_sts;
   endsequence

   sequence s_no_read;
      !rd_ctl && !rd_sts;
   endsequence

   sequence s_low_clear(int bit_pos);
      wr_ctl && cfg_be[0] && !cfg_wdata[bit_pos];
   endsequence

   sequence s_no_enable;
      !s.ctl[link_control_pkg::BIT_ABW_IE] && !s.ctl[link_control_pkg::BIT_BWM_IE];
   endsequence

   a_read_answer: assert property (cfg_rd // RULE_16
      |=> cfg_rvalid)
      else $error("read not answered");

   a_read_quiet: assert property (!cfg_rd // RULE_16
      |=> !cfg_rvalid)
      else $error("read valid without a read");

   a_idle_rdata: assert property (s_no_read // RULE_16
      |=> cfg_rdata == 16'h0000)
      else $error("read data not zero outside a mapped read");

   a_ctl_readback: assert property (s_ctl_read // RULE_06
      |=> cfg_rdata == $past(s.ctl))
      else $error("control read does not return stored value");

   a_ctl_hold: assert property (!wr_ctl // RULE_16
      |=> $stable(s.ctl))
      else $error("control changed without a write");

   a_rsvd_store: assert property (wr_ctl // RULE_16
      |=> (s.ctl & link_control_pkg::CTL_ZERO_MASK) == 16'h0000)
      else $error("reserved or fixed bit stored");

   a_high_lane: assert property (wr_ctl && !cfg_be[1] // RULE_01
      |=> $stable(s.ctl[link_control_pkg::BIT_ABW_IE]))
      else $error("disabled byte lane written");

   a_ext_clear: assert property (s_low_clear(link_control_pkg::BIT_EXT_SYNC) // RULE_05
      |=> !ext_sync)
      else $error("extended sync not cleared");

   a_l0s_clear: assert property (s_low_clear(link_control_pkg::BIT_ASPM_LO) // RULE_15
      |=> !l0s_tx_en)
      else $error("transmit L0s enabled for even field");

   a_recovery_cause: assert property (to_recovery // RULE_08
      |-> $past(retrain_ok))
      else $error("recovery requested without accepted retrain");

   a_speed_pair: assert property (speed_change // RULE_10
      |-> to_recovery)
      else $error("speed change without recovery");

   a_speed_same: assert property (s_retrain_active and (target_speed == cur_speed) // RULE_10
      |=> !speed_change)
      else $error("speed change to present speed");

   a_speed_none: assert property (s_retrain_active // RULE_10
      and (target_speed == link_control_pkg::SPEED_NONE) |=> !speed_change)
      else $error("speed change with zero target");

   a_speed_hold: assert property (!retrain_ok // RULE_11
      |=> $stable(retrain_speed))
      else $error("retrain speed changed without retrain");

   a_disable_bit: assert property (to_disabled // RULE_12
      |-> s.ctl[link_control_pkg::BIT_DISABLE])
      else $error("disable request without disable bit");

   a_disable_early: assert property (!link_control_pkg::past_polling(st) // RULE_12
      |=> !to_disabled)
      else $error("disable request before polling passed");

   a_detect_bit: assert property (to_detect // RULE_13
      |-> !s.ctl[link_control_pkg::BIT_DISABLE])
      else $error("detect request while disable set");

   a_detect_state: assert property (st != link_control_pkg::ST_DISABLED // RULE_13
      |=> !to_detect)
      else $error("detect request outside disabled state");

   a_irq_masked: assert property (s_no_enable // RULE_02
      |=> !bw_intr)
      else $error("interrupt with both enables clear");

   a_train_status: assert property (s_sts_read // RULE_18
      |=> cfg_rdata[link_control_pkg::STS_TRAIN] == $past(ev.training))
      else $error("training flag read wrong");

   a_bwm_status: assert property (s_sts_read // RULE_17
      |=> cfg_rdata[link_control_pkg::STS_BWM] == $past(ev.bwm_status))
      else $error("bandwidth management flag read wrong");

   a_abw_status: assert property (s_sts_read // RULE_01
      |=> cfg_rdata[link_control_pkg::STS_ABW] == $past(ev.abw_status))
      else $error("autonomous bandwidth flag read wrong");
endmodule

// >>> link_control_pkg.sv
// Notes on behaviour
// [RULE_01] Autonomous bandwidth status becoming set raises interrupt when bit 11 is one.
// [RULE_02] Bandwidth management status becoming set raises interrupt when bit 10 is one.
// [RULE_03] Port never changes configured width autonomously; bit 9 reads zero.
// [RULE_04] Clock power management bit 8 has no function and reads zero.
// [RULE_05] Bit 7 forces extra ordered sets on L0s exit and in recovery.
// [RULE_06] Common clock configuration bit 6 has no effect on behaviour.
// [RULE_07] Writing one to bit 5 in L0, L0s or L1 requests recovery.
// [RULE_08] Retrain written in any other training state is ignored.
// [RULE_09] Retrain bit always reads zero.
// [RULE_10] Retraining targets nonzero target speed that differs from current speed.
// [RULE_11] Fields written with retrain in one access apply to that retraining.
// [RULE_12] Disable bit one moves a link past polling to disabled.
// [RULE_13] Disable bit zero returns a disabled state machine to detect.
// [RULE_14] Read completion boundary bit 3 reads zero, 64-byte split completions.
// [RULE_15] Field 1:0 at 01b or 11b enables transmit L0s, else disabled.
// [RULE_16] Reserved bits 15:12 and 2 read zero, writes ignored.
// [RULE_17] Bandwidth management status sets when commanded retrain completes without link down.
// [RULE_18] Training flag reads one from retrain request until recovery/configuration is left.
package link_control_pkg;
   localparam logic [11:0] LINK_CONTROL_OFS = 12'h050;
   localparam logic [11:0] LINK_STATUS_OFS = 12'h052;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] CTL_WR_MASK = 16'h0CD3;
   localparam logic [15:0] CTL_ZERO_MASK = 16'hF32C;
   localparam logic [3:0] SPEED_NONE = 4'h0;
   localparam int BIT_ASPM_LO = 0;
   localparam int BIT_ASPM_HI = 1;
   localparam int BIT_RSVD_LO = 2;
   localparam int BIT_RCB = 3;
   localparam int BIT_DISABLE = 4;
   localparam int BIT_RETRAIN = 5;
   localparam int BIT_COM_CLK = 6;
   localparam int BIT_EXT_SYNC = 7;
   localparam int BIT_CLK_PM = 8;
   localparam int BIT_AUTO_WIDTH = 9;
   localparam int BIT_BWM_IE = 10;
   localparam int BIT_ABW_IE = 11;
   localparam int BIT_RSVD_HI = 12;
   localparam int STS_TRAIN = 11;
   localparam int STS_BWM = 14;
   localparam int STS_ABW = 15;

   typedef enum logic [3:0] {
      ST_DETECT = 4'h0,
      ST_POLLING = 4'h1,
      ST_CONFIG = 4'h2,
      ST_L0 = 4'h3,
      ST_L0S = 4'h4,
      ST_L1 = 4'h5,
      ST_L2 = 4'h6,
      ST_RECOVERY = 4'h7,
      ST_DISABLED = 4'h8,
      ST_LOOPBACK = 4'h9,
      ST_HOT_RESET = 4'hA
   } ltssm_type;

   function automatic logic in_active(input ltssm_type st);
      return st == ST_L0 || st == ST_L0S || st == ST_L1;
   endfunction

   function automatic logic in_training(input ltssm_type st);
      return st == ST_RECOVERY || st == ST_CONFIG;
   endfunction

   function automatic logic past_polling(input ltssm_type st);
      return st != ST_DETECT && st != ST_POLLING;
   endfunction

   function automatic logic aspm_l0s(input logic [1:0] aspm);
      return aspm == 2'h1 || aspm == 2'h3;
   endfunction

   function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [15:0] wd,
                                               input logic [1:0] be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction
endpackage

// >>> link_event_if.sv
`timescale 1ns/100ps
interface link_event_if;
   link_control_pkg::ltssm_type ltssm;
   logic link_down;
   logic auto_bw_event;
   logic retrain_go;
   logic clr_bwm;
   logic clr_abw;
   logic training;
   logic bwm_status;
   logic abw_status;
   logic bwm_set_pulse;
   logic abw_set_pulse;

   modport tracker (
      input ltssm, link_down, auto_bw_event, retrain_go, clr_bwm, clr_abw,
      output training, bwm_status, abw_status, bwm_set_pulse, abw_set_pulse
   );
   modport bank (
      output ltssm, link_down, auto_bw_event, retrain_go, clr_bwm, clr_abw,
      input training, bwm_status, abw_status, bwm_set_pulse, abw_set_pulse
   );
endinterface

// >>> link_event_tracker.sv
`timescale 1ns/100ps
module link_event_tracker (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Synchronous reset
   link_event_if.tracker ev // Status events to and from the bank
);
   typedef struct packed {
      logic pend;
      logic track;
      logic training;
      logic bwm;
      logic abw;
      logic bwm_pulse;
      logic abw_pulse;
   } tracker_state_type;

   tracker_state_type s;
   tracker_state_type next_s;
   logic bwm_evt;
   logic abw_evt;

   // Commanded retrain finished back in L0 with the link still up
   assign bwm_evt = s.track && ev.ltssm == link_control_pkg::ST_L0 && !ev.link_down; // RULE_17
   assign abw_evt = ev.auto_bw_event;

   always_comb
   begin
      next_s = s;
      if (ev.retrain_go)
         next_s.pend = 1'b1;
      else if (link_control_pkg::in_training(ev.ltssm))
         next_s.pend = 1'b0;
      if (s.pend && link_control_pkg::in_training(ev.ltssm))
         next_s.track = 1'b1;
      else if (bwm_evt)
         next_s.track = 1'b0;
      if (ev.link_down)
      begin
         next_s.pend = 1'b0;
         next_s.track = 1'b0;
      end
      next_s.training = next_s.pend || link_control_pkg::in_training(ev.ltssm); // RULE_18
      // Set wins over a clear in the same cycle
      next_s.bwm = bwm_evt || (s.bwm && !ev.clr_bwm); // RULE_17
      next_s.abw = abw_evt || (s.abw && !ev.clr_abw);
      next_s.bwm_pulse = bwm_evt && (!s.bwm || ev.clr_bwm);
      next_s.abw_pulse = abw_evt && (!s.abw || ev.clr_abw);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   assign ev.training = s.training;
   assign ev.bwm_status = s.bwm;
   assign ev.abw_status = s.abw;
   assign ev.bwm_set_pulse = s.bwm_pulse;
   assign ev.abw_set_pulse = s.abw_pulse;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_train_done;
      s.track && ev.ltssm == link_control_pkg::ST_L0 && !ev.link_down;
   endsequence

   a_train_flag: assert property (ev.retrain_go |=> ev.training) // RULE_18
      else $error("training flag not raised by retrain");
   a_bwm_done: assert property (s_train_done |=> ev.bwm_status) // RULE_17
      else $error("bandwidth status not set after retrain");
   a_bwm_down: assert property (ev.link_down && !s.bwm |=> !ev.bwm_status) // RULE_17
      else $error("bandwidth status set across link down");
endmodule

// >>> ltssm_partner.sv
`timescale 1ns/100ps
module ltssm_partner (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Synchronous reset
   input wire logic to_recovery, // Retrain request
   input wire logic to_disabled, // Disable level
   input wire logic to_detect, // Re-enable level
   input wire logic set_en, // Bench holds a state
   input wire logic [3:0] set_state, // Held state
   input wire logic [3:0] dwell, // Step length minus one, in cycles
   output logic [3:0] ltssm_state // Training state
);
   logic [3:0] cnt;
   always_ff @(posedge clk)
   begin
      cnt <= (cnt == dwell) ? 4'h0 : cnt + 4'h1;
      if (!rst_n)
      begin
         cnt <= 4'h0;
         ltssm_state <= link_control_pkg::ST_DETECT;
      end
      else if (set_en)
         ltssm_state <= set_state;
      else if (to_disabled)
         ltssm_state <= link_control_pkg::ST_DISABLED;
      else if (to_detect)
         ltssm_state <= link_control_pkg::ST_DETECT;
      else if (to_recovery)
         ltssm_state <= link_control_pkg::ST_RECOVERY;
      else if (cnt == dwell && ltssm_state < 4'h3)
         ltssm_state <= ltssm_state + 4'h1;
      else if (cnt == dwell && ltssm_state == link_control_pkg::ST_RECOVERY)
         ltssm_state <= link_control_pkg::ST_L0;
   end
endmodule

// >>> pcie_link_control_register_test.sv
`timescale 1ns/100ps
module pcie_link_control_register_test;
   logic clk, rst_n, cfg_wr, cfg_rd, link_down, auto_bw_event, set_en, cfg_rvalid, to_recovery;
   logic speed_change, to_disabled, to_detect, ext_sync, l0s_tx_en, bw_intr;
   logic [11:0] cfg_addr;
   logic [1:0] cfg_be, be;
   logic [15:0] cfg_wdata, cfg_rdata, d, ctl;
   logic [3:0] ltssm_state, cur_speed, target_speed, retrain_speed, set_state, dwell;
   int errors = 0, cmp_count = 0, cyc = 0, icnt = 0, iexp = 0;

   link_control_bank dut_u (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .ltssm_state(ltssm_state), .link_down(link_down),
      .auto_bw_event(auto_bw_event), .cur_speed(cur_speed), .target_speed(target_speed),
      .to_recovery(to_recovery), .speed_change(speed_change), .retrain_speed(retrain_speed),
      .to_disabled(to_disabled), .to_detect(to_detect), .ext_sync(ext_sync),
      .l0s_tx_en(l0s_tx_en), .bw_intr(bw_intr));
   ltssm_partner partner_u (.clk(clk), .rst_n(rst_n), .to_recovery(to_recovery),
      .to_disabled(to_disabled), .to_detect(to_detect), .set_en(set_en),
      .set_state(set_state), .dwell(dwell), .ltssm_state(ltssm_state));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk)
   begin
      cyc++;
      if (bw_intr === 1'b1)
         icnt++;
      if (cyc == 5000)
      begin
         errors++;
         results();
      end
   end
   task automatic results();
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Select 0 control, 1 status, 2 unmapped
   task automatic wr(input logic [1:0] s, input logic [15:0] v, input logic [1:0] b);
      cfg_wr = 1'b1;
      cfg_addr = 12'h050 + {9'h0, s, 1'b0};
      cfg_be = b;
      cfg_wdata = v;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask
   task automatic rdchk(input logic [1:0] s, input logic [15:0] e);
      cfg_rd = 1'b1;
      cfg_addr = 12'h050 + {9'h0, s, 1'b0};
      @(negedge clk);
      cfg_rd = 1'b0;
      chk({15'h0, cfg_rvalid}, 16'h0001);
      chk(cfg_rdata, e);
   endtask
   task automatic wait_state(input logic [3:0] s);
      for (int k = 0; k < 100 && ltssm_state !== s; k++)
         @(negedge clk);
      chk({12'h0, ltssm_state}, {12'h0, s});
   endtask
   task automatic bw_event();
      auto_bw_event = 1'b1;
      @(negedge clk);
      auto_bw_event = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   function automatic logic l0s_exp(input logic [1:0] f);
      return f == 2'h1 || f == 2'h3;
   endfunction

   initial
   begin
      {rst_n, cfg_wr, cfg_rd, link_down, auto_bw_event, set_en} = 6'h00;
      cfg_addr = 12'h000;
      cfg_be = 2'h0;
      cfg_wdata = 16'h0000;
      {cur_speed, target_speed, set_state, dwell} = 16'h2002;
      ctl = 16'h0000;
      void'($urandom(32'hEA4EAE02));
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      rdchk(2'h0, 16'h0000);
      wait_state(link_control_pkg::ST_L0);
      for (int i = 0; i < 40; i++)
      begin
         d = 16'($urandom) & 16'hFFCF;
         d[1:0] = 2'(i);
         be = 2'($urandom) | {1'b0, i < 4};
         {cur_speed, target_speed} = 8'($urandom);
         wr(2'h0, d, be);
         if (be[0])
            ctl[7:0] = d[7:0] & 8'hD3;
         if (be[1])
            ctl[15:8] = d[15:8] & 8'h0C;
         chk({15'h0, l0s_tx_en}, {15'h0, l0s_exp(ctl[1:0])});
         chk({15'h0, ext_sync}, {15'h0, ctl[7]});
         rdchk(2'h0, ctl);
      end
      wr(2'h2, 16'hFFFF, 2'h3);
      rdchk(2'h2, 16'h0000);
      @(negedge clk);
      rdchk(2'h0, ctl);
      cur_speed = 4'h2;
      for (int i = 0; i < 3; i++)
      begin
         target_speed = (i == 0) ? 4'h0 : 4'(i + 1);
         dwell = 4'(1 + 5 * i);
         set_en = 1'b1;
         set_state = 4'(3 + i);
         @(negedge clk);
         set_en = 1'b0;
         d = 16'h00A1 | {5'h0, i != 0, 10'h0};
         wr(2'h0, d, 2'h3);
         chk({15'h0, to_recovery}, 16'h0001);
         chk({15'h0, speed_change}, {15'h0, i == 2});
         chk({11'h0, retrain_speed, ext_sync}, {11'h0, target_speed, 1'b1});
         rdchk(2'h0, d & 16'h0CD3);
         chk({15'h0, to_recovery}, 16'h0000);
         @(negedge clk);
         rdchk(2'h1, 16'h0800);
         wait_state(link_control_pkg::ST_L0);
         repeat (3) @(negedge clk);
         iexp += (i != 0);
         rdchk(2'h1, 16'h4000);
         chk(16'(icnt), 16'(iexp));
         wr(2'h1, 16'h4000, 2'h2);
      end
      // Link drops during a commanded retrain
      @(negedge clk);
      wr(2'h0, 16'h0420, 2'h3);
      link_down = 1'b1;
      wait_state(link_control_pkg::ST_RECOVERY);
      wait_state(link_control_pkg::ST_L0);
      repeat (3) @(negedge clk);
      link_down = 1'b0;
      repeat (3) @(negedge clk);
      rdchk(2'h1, 16'h0000);
      chk(16'(icnt), 16'(iexp));
      for (int s = 0; s < 11; s++)
      begin
         if (s >= 3 && s <= 5)
            continue;
         set_en = 1'b1;
         set_state = 4'(s);
         @(negedge clk);
         wr(2'h0, 16'h0020, 2'h1);
         chk({15'h0, to_recovery}, 16'h0000);
         @(negedge clk);
         chk({15'h0, to_recovery}, 16'h0000);
      end
      set_state = link_control_pkg::ST_POLLING;
      @(negedge clk);
      wr(2'h0, 16'h0010, 2'h1);
      repeat (2) @(negedge clk);
      chk({15'h0, to_disabled}, 16'h0000);
      set_en = 1'b0;
      wait_state(link_control_pkg::ST_DISABLED);
      chk({15'h0, to_disabled}, 16'h0001);
      wr(2'h0, 16'h0000, 2'h1);
      chk({15'h0, to_detect}, 16'h0001);
      wait_state(link_control_pkg::ST_DETECT);
      wait_state(link_control_pkg::ST_L0);
      @(negedge clk);
      rdchk(2'h1, 16'h0000);
      wr(2'h0, 16'h0000, 2'h2);
      bw_event();
      rdchk(2'h1, 16'h8000);
      chk(16'(icnt), 16'(iexp));
      wr(2'h1, 16'h8000, 2'h2);
      rdchk(2'h1, 16'h0000);
      wr(2'h0, 16'h0800, 2'h2);
      bw_event();
      bw_event();
      iexp += 1;
      chk(16'(icnt), 16'(iexp));
      // Event in the same cycle as the clear
      auto_bw_event = 1'b1;
      wr(2'h1, 16'h8000, 2'h2);
      auto_bw_event = 1'b0;
      repeat (2) @(negedge clk);
      iexp += 1;
      rdchk(2'h1, 16'h8000);
      chk(16'(icnt), 16'(iexp));
      results();
   end
endmodule
